// *** logic/tpl_top.sv ***
// Probe latch with position and time stamp capture over AXI4-Lite
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tpl_map.svh"

// Notes on behaviour
// - Status bit 0 mirrors probe enable
// - Bit 1 sets after rising pair stored
// - Function bit 4 low clears rising flag
// - Bit 2 sets after falling pair stored
// - Function bit 5 low clears falling flag
// - Continuous mode toggles bit 6 per rise
// - Continuous mode toggles bit 7 per fall
// - Reserved status bits carry no meaning
// - Enable plus both samples arms both edges while both flags are clear
// - Armed edge stores position, stamp and flag together
// - Rise sample off clears flag, keeps data
// - Rise sample on rearms without touching data
// - Disable clears flags, latched data kept
module tpl_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        probe_in,
    input  wire logic [31:0] pos_fb,
    output logic             irq
);

    // ============================================================
    // State and helper terms
    tpl_pkg::tpl_state_s q;
    tpl_pkg::tpl_state_s d;
    logic                rise_ev;
    logic                fall_ev;
    logic                en;
    logic                cont;
    logic                rise_arm;
    logic                fall_arm;
    logic                rise_hit;
    logic                fall_hit;
    logic [15:0]         status_w;
    logic                ar_take;
    logic                wr_go;
    logic [13:0]         ridx;

    // Edge seen between second and third stage only
    assign rise_ev  = q.sync[1] & ~q.sync[2];
    assign fall_ev  = ~q.sync[1] & q.sync[2];
    assign en       = q.func[`TPL_FN_EN];
    assign cont     = q.func[`TPL_FN_CONT];
    // Single shot waits for software to drop the sample bit
    assign rise_arm = en & q.func[`TPL_FN_RISE] & (cont | ~q.stored_r);
    assign fall_arm = en & q.func[`TPL_FN_FALL] & (cont | ~q.stored_f);
    assign rise_hit = rise_ev & rise_arm;
    assign fall_hit = fall_ev & fall_arm;
    assign ar_take  = s_axi_arvalid & q.arready;
    assign wr_go    = q.aw_have & q.w_have & ~q.bvalid;
    assign ridx     = s_axi_araddr[15:2];

    // Reserved bits read as zero
    always_comb begin
        status_w                   = 16'h0000;
        status_w[`TPL_ST_EN]       = en;
        status_w[`TPL_ST_RISE]     = q.stored_r;
        status_w[`TPL_ST_FALL]     = q.stored_f;
        status_w[`TPL_ST_TOG_RISE] = q.tog_r;
        status_w[`TPL_ST_TOG_FALL] = q.tog_f;
    end

    // ============================================================
    // Next state
    always_comb begin
        d        = q;
        d.sync   = {q.sync[1:0], probe_in};
        d.ts_cnt = q.ts_cnt + 32'h0000_0001;

        // Capture pair and flag on the same edge
        if (rise_hit) begin
            d.rise.pos = pos_fb;
            d.rise.ts  = q.ts_cnt;
            d.stored_r = 1'b1;
            if (cont) begin
                d.tog_r = ~q.tog_r;
            end
        end
        if (fall_hit) begin
            d.fall.pos = pos_fb;
            d.fall.ts  = q.ts_cnt;
            d.stored_f = 1'b1;
            if (cont) begin
                d.tog_f = ~q.tog_f;
            end
        end
        // Latched data is never touched here
        if (!q.func[`TPL_FN_RISE] || !en) begin
            d.stored_r = 1'b0;
        end
        if (!q.func[`TPL_FN_FALL] || !en) begin
            d.stored_f = 1'b0;
        end

        // Write channel: address and data in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.waddr   = s_axi_awaddr[15:2];
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (wr_go) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = `TPL_RESP_OKAY;
            case (q.waddr)
                `TPL_IDX_FUNC: begin
                    if (q.wstrb[0]) begin
                        d.func[7:0] = q.wdata[7:0] & 8'(`TPL_FN_WMASK);
                    end
                    if (q.wstrb[1]) begin
                        d.func[15:8] = 8'h00;
                    end
                end
                `TPL_IDX_IRQ_MASK: begin
                    if (q.wstrb[0]) begin
                        d.irq_mask = q.wdata[1:0];
                    end
                end
                `TPL_IDX_STATUS, `TPL_IDX_POS_RISE, `TPL_IDX_POS_FALL,
                `TPL_IDX_TS_RISE, `TPL_IDX_TS_FALL, `TPL_IDX_IRQ_STAT: begin
                    d.bresp = `TPL_RESP_OKAY;
                end
                default: begin
                    d.bresp = `TPL_RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        d.awready = ~d.aw_have & ~d.bvalid;
        d.wready  = ~d.w_have & ~d.bvalid;

        // Read channel; status of interrupts clears on read
        if (ar_take) begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rresp   = `TPL_RESP_OKAY;
            case (ridx)
                `TPL_IDX_FUNC:     d.rdata = {16'h0000, q.func};
                `TPL_IDX_STATUS:   d.rdata = {16'h0000, status_w};
                `TPL_IDX_POS_RISE: d.rdata = q.rise.pos;
                `TPL_IDX_POS_FALL: d.rdata = q.fall.pos;
                `TPL_IDX_TS_RISE:  d.rdata = q.rise.ts;
                `TPL_IDX_TS_FALL:  d.rdata = q.fall.ts;
                `TPL_IDX_IRQ_STAT: begin
                    d.rdata    = {30'h0000_0000, q.irq_stat};
                    d.irq_stat = 2'h0;
                end
                `TPL_IDX_IRQ_MASK: d.rdata = {30'h0000_0000, q.irq_mask};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = `TPL_RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end

        // Set wins over a clearing read in the same cycle
        if (rise_hit) begin
            d.irq_stat[`TPL_IRQ_RISE] = 1'b1;
        end
        if (fall_hit) begin
            d.irq_stat[`TPL_IRQ_FALL] = 1'b1;
        end
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    // ============================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q          <= '0;
            q.func     <= `TPL_FUNC_RST;
            q.irq_mask <= `TPL_MASK_RST;
            q.arready  <= 1'b1;
            q.awready  <= 1'b1;
            q.wready   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign irq           = q.irq;

    // ============================================================
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    en_status_a: assert property (
        ar_take && ridx == `TPL_IDX_STATUS
        |=> s_axi_rdata[`TPL_ST_EN] == $past(q.func[`TPL_FN_EN]))
        else $error("enable status differs from function bit");

    rise_latch_a: assert property (
        rise_hit |=> q.stored_r && q.rise.pos == $past(pos_fb)
                     && q.rise.ts == $past(q.ts_cnt))
        else $error("rising pair or flag not stored");

    rise_clear_a: assert property (
        !q.func[`TPL_FN_RISE] |=> !q.stored_r)
        else $error("rising flag kept with sample bit low");

    fall_latch_a: assert property (
        fall_hit |=> q.stored_f && q.fall.pos == $past(pos_fb)
                     && q.fall.ts == $past(q.ts_cnt))
        else $error("falling pair or flag not stored");

    fall_clear_a: assert property (
        !q.func[`TPL_FN_FALL] |=> !q.stored_f)
        else $error("falling flag kept with sample bit low");

    tog_rise_a: assert property (
        rise_hit && cont |=> q.tog_r != $past(q.tog_r))
        else $error("rising toggle did not invert");

    tog_fall_a: assert property (
        fall_hit && cont |=> q.tog_f != $past(q.tog_f))
        else $error("falling toggle did not invert");

    rsvd_zero_a: assert property (
        status_w[5:3] == 3'h0 && status_w[15:8] == 8'h00)
        else $error("reserved status bits not zero");

    arm_both_a: assert property (
        en && q.func[`TPL_FN_RISE] && q.func[`TPL_FN_FALL]
        && !q.stored_r && !q.stored_f |-> rise_arm && fall_arm)
        else $error("edges not armed");

    keep_data_a: assert property (
        !rise_hit |=> $stable(q.rise))
        else $error("rising latch changed without an edge");

    rearm_a: assert property (
        $rose(q.func[`TPL_FN_RISE]) && en && !rise_ev
        |=> $stable(q.rise))
        else $error("rearm altered latched data");

    dis_clear_a: assert property (
        !en |=> !q.stored_r && !q.stored_f && $stable(q.fall))
        else $error("disable left a flag set or changed data");

    one_event_a: assert property (
        rise_ev |=> !rise_ev ##1 !rise_ev)
        else $error("one edge produced repeated events");

    rise_seen_c: cover property (rise_hit ##[1:50] fall_hit);
    cont_tog_c:  cover property (rise_hit && cont ##[1:50] rise_hit);
    irq_c:       cover property ($rose(q.irq));
    rearm_c:     cover property ($rose(q.func[`TPL_FN_RISE]) ##[1:50] rise_hit);

endmodule

// *** include/tpl_map.svh ***
// Register map, field positions, reset values and timing of the probe latch
`ifndef TPL_MAP_SVH
`define TPL_MAP_SVH

// ============================================================
// Register word indices (byte address is four times the index)
`define TPL_IDX_FUNC      14'h2de8
`define TPL_IDX_STATUS    14'h2de9
`define TPL_IDX_POS_RISE  14'h2dea
`define TPL_IDX_POS_FALL  14'h2deb
`define TPL_IDX_TS_RISE   14'h2df8
`define TPL_IDX_TS_FALL   14'h2df9
`define TPL_IDX_IRQ_STAT  14'h2e00
`define TPL_IDX_IRQ_MASK  14'h2e01

// ============================================================
// Function word fields
`define TPL_FN_EN         0
`define TPL_FN_CONT       1
`define TPL_FN_RISE       4
`define TPL_FN_FALL       5
`define TPL_FN_WMASK      16'h0033

// ============================================================
// Status word fields
`define TPL_ST_EN         0
`define TPL_ST_RISE       1
`define TPL_ST_FALL       2
`define TPL_ST_TOG_RISE   6
`define TPL_ST_TOG_FALL   7

// ============================================================
// Interrupt bits, reset values, responses
`define TPL_IRQ_RISE      0
`define TPL_IRQ_FALL      1
`define TPL_FUNC_RST      16'h0000
`define TPL_MASK_RST      2'h0
`define TPL_RESP_OKAY     2'h0
`define TPL_RESP_SLVERR   2'h2

// ============================================================
// Probe input timing owed by the sensor side
`define TPL_PROBE_MIN_US  500

`endif

// *** include/tpl_pkg.sv ***
// Types shared by the probe latch design
package tpl_pkg;

    typedef struct packed {
        logic [31:0] pos;
        logic [31:0] ts;
    } tpl_latch_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        aw_have;
        logic        w_have;
        logic [13:0] waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [15:0] func;
        logic        stored_r;
        logic        stored_f;
        logic        tog_r;
        logic        tog_f;
        tpl_latch_s  rise;
        tpl_latch_s  fall;
        logic [31:0] ts_cnt;
        logic [2:0]  sync;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        irq;
    } tpl_state_s;

endpackage

// *** testbench/tpl_probe_model.sv ***
// Probe sensor and position feedback model for the probe latch bench
`timescale 1ns/1ps

// ============================================================
// Sensor model
module tpl_probe_model #(
    parameter int          HOLD     = 10000,
    parameter logic [31:0] POS_BASE = 32'h0000_1000
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        want_level,
    output logic             probe_in,
    output logic [31:0]      pos_fb
);
    logic [15:0] held_q;
    logic        level_q;
    logic [31:0] pos_q;

    // Request waits out the minimum level time, never shortens it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            held_q  <= 16'h0;
            level_q <= 1'b0;
            pos_q   <= POS_BASE;
        end else begin
            pos_q <= pos_q + 32'h1;
            if (want_level != level_q && held_q >= 16'(HOLD - 1)) begin
                level_q <= want_level;
                held_q  <= 16'h0;
            end else if (held_q < 16'(HOLD)) begin
                held_q <= held_q + 16'h1;
            end
        end
    end

    assign probe_in = level_q;
    assign pos_fb   = pos_q;
endmodule

// *** testbench/tpl_tb_top.sv ***
// Self-checking bench for the probe latch over its register bus
`timescale 1ns/1ps
`include "tpl_map.svh"

// ============================================================
// Bench top
module tpl_tb_top;
    localparam logic [31:0] POS_BASE = 32'h0000_1000;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, want = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, probe;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, pos, rv, p_r, t_r;
    int          n_errors = 0, cmp_count = 0, cyc = 0;

    always #25 aclk = ~aclk;

    tpl_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .probe_in(probe),
        .pos_fb(pos), .irq(irq));

    tpl_probe_model #(.HOLD(10000), .POS_BASE(POS_BASE)) u_probe (
        .aclk(aclk), .aresetn(aresetn), .want_level(want),
        .probe_in(probe), .pos_fb(pos));

    // ============================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [13:0] i, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= {i, 2'b00};
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 100);
        r = bresp;
        bready <= 1'b0;
        if (n >= 100) n_errors++;
        // Let an edge pass so the next call never re-raises bready at once
        @(posedge aclk);
    endtask

    task automatic rd(input logic [13:0] i, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) n_errors++;
        // Let an edge pass so the next call never re-raises rready at once
        @(posedge aclk);
    endtask

    task automatic rc(input string nm, input logic [13:0] i,
                      input logic [31:0] e);
        rd(i, rv, rs);
        chk(nm, e, rv);
    endtask

    // Position and stamp share one sampling cycle, so differ by the base
    task automatic pair(input logic [13:0] pi, input logic [13:0] ti);
        rd(pi, p_r, rs);
        rd(ti, t_r, rs);
        chk("pos_vs_stamp", t_r + POS_BASE, p_r);
    endtask

    // Latch lands about three edges after the pin; eight leaves margin
    task automatic edge_to(input logic lv);
        int n;
        n = 0;
        want <= lv;
        do begin
            @(posedge aclk);
            n++;
        end while (probe !== lv && n < 20000);
        if (probe !== lv) n_errors++;
        repeat (8) @(posedge aclk);
    endtask

    task automatic done_t(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, n_errors);
    endtask

    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ============================================================
    // Hang guard: six probe levels of 10000 cycles fit well below it
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            final_report();
        end
    end

    // ============================================================
    // Scenarios
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc("func", `TPL_IDX_FUNC, 32'h0);
        rc("status", `TPL_IDX_STATUS, 32'h0);
        rc("irq_mask", `TPL_IDX_IRQ_MASK, 32'h0);
        rd(14'h0100, rv, rs);
        chk("rresp", {30'h0, `TPL_RESP_SLVERR}, {30'h0, rs});
        wr(14'h0100, 32'h1, rs);
        chk("bresp", {30'h0, `TPL_RESP_SLVERR}, {30'h0, rs});
        done_t("reset");
        wr(`TPL_IDX_FUNC, 32'h31, rs);
        rc("status", `TPL_IDX_STATUS, 32'h1);
        edge_to(1'b1);
        rc("status", `TPL_IDX_STATUS, 32'h3);
        pair(`TPL_IDX_POS_RISE, `TPL_IDX_TS_RISE);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`TPL_IDX_IRQ_MASK, 32'h3, rs);
        chk("irq", 32'h1, {31'h0, irq});
        rc("irq_stat", `TPL_IDX_IRQ_STAT, 32'h1);
        rc("irq_stat", `TPL_IDX_IRQ_STAT, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        done_t("rise");
        edge_to(1'b0);
        rc("status", `TPL_IDX_STATUS, 32'h7);
        pair(`TPL_IDX_POS_FALL, `TPL_IDX_TS_FALL);
        rc("irq_stat", `TPL_IDX_IRQ_STAT, 32'h2);
        pair(`TPL_IDX_POS_RISE, `TPL_IDX_TS_RISE);
        done_t("fall");
        wr(`TPL_IDX_FUNC, 32'h21, rs);
        rc("status", `TPL_IDX_STATUS, 32'h5);
        rc("pos_rise", `TPL_IDX_POS_RISE, p_r);
        wr(`TPL_IDX_FUNC, 32'h31, rs);
        rc("status", `TPL_IDX_STATUS, 32'h5);
        rc("pos_rise", `TPL_IDX_POS_RISE, p_r);
        rv = p_r;
        edge_to(1'b1);
        rc("status", `TPL_IDX_STATUS, 32'h7);
        pair(`TPL_IDX_POS_RISE, `TPL_IDX_TS_RISE);
        chk("fresh", 32'h1, {31'h0, p_r > rv});
        done_t("rearm");
        wr(`TPL_IDX_FUNC, 32'h11, rs);
        rc("status", `TPL_IDX_STATUS, 32'h3);
        wr(`TPL_IDX_FUNC, 32'h0, rs);
        rc("status", `TPL_IDX_STATUS, 32'h0);
        rc("pos_rise", `TPL_IDX_POS_RISE, p_r);
        rc("ts_rise", `TPL_IDX_TS_RISE, t_r);
        done_t("disable");
        wr(`TPL_IDX_FUNC, 32'h33, rs);
        edge_to(1'b0);
        rc("status", `TPL_IDX_STATUS, 32'h85);
        edge_to(1'b1);
        rc("status", `TPL_IDX_STATUS, 32'hc7);
        edge_to(1'b0);
        rc("status", `TPL_IDX_STATUS, 32'h47);
        done_t("continuous");
        final_report();
    end
endmodule
